// ### src/csie_top.sv
// Purpose: Socket interrupt events: flags, masks, routing and pin signalling.
// Assumes: Card pins synchronous to mclk_in, asserted high at the ports, except the detect pins, which an inserted card grounds.
// Notes: Multifunction pins are open drain except driven ISA IRQ levels.
//
// Design decisions made here: register access over APB and the register offsets.
module csie_top (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [csie_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  // Card socket pins
  input wire logic card_detect_one_in,
  input wire logic card_detect_two_in,
  input wire logic battery_detect_one_in,
  input wire logic battery_detect_two_in,
  input wire logic card_ready_in,
  input wire logic power_cycle_done_in,
  // Request of the companion socket function
  input wire logic other_socket_irq_in,
  // Multifunction pins
  input wire logic [csie_pkg::MF_PINS-1:0] multifunction_pins_in,
  output logic [csie_pkg::MF_PINS-1:0] multifunction_pins_out,
  output logic [csie_pkg::MF_PINS-1:0] multifunction_pins_oe_out
);
  import csie_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] ctrl;
    logic [27:0] route;
    logic [3:0] lmask;
    logic [3:0] smask;
    csie_ser_state_type ser;
    logic [4:0] cnt;
    logic [4:0] slot;
    logic [MF_PINS-1:0] mf_out;
    logic [MF_PINS-1:0] mf_oe;
  } csie_top_state_type;

  csie_top_state_type st_r;
  csie_top_state_type st_nxt;

  csie_flag_if #(.W(FLAG_W)) leg_if ();
  csie_flag_if #(.W(FLAG_W)) sock_if ();

  logic [1:0] card_type;
  logic [1:0] mode;
  logic is_mem;
  logic is_io;
  logic is_cb;
  logic clr_by_write;
  logic tie;
  logic csc_isa;
  logic fn_isa;
  logic [3:0] csc_irq;
  logic [3:0] fn_irq;
  logic io_card_irq_request;
  logic cardbus_irq_request;
  logic func_req;
  logic csc_req;
  logic present;
  logic acc;
  logic done;
  logic wr_done;
  logic rd_done;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [15:0] isa;
  logic f0_pci;
  logic inta;
  logic intb;
  logic ser_mode;
  logic ser_pci;
  logic [17:0] ser_lines;
  logic ser_drive;

  // ----------------------------------------------------------------
  // Control field decode
  // ----------------------------------------------------------------
  assign card_type = st_r.ctrl[CT_TYPE_LSB +: 2];
  assign mode = st_r.ctrl[CT_MODE_LSB +: 2];
  assign clr_by_write = st_r.ctrl[CT_W1C_BIT];
  assign tie = st_r.ctrl[CT_TIE_BIT];
  assign csc_isa = st_r.ctrl[CT_CSC_ISA_BIT];
  assign fn_isa = st_r.ctrl[CT_FN_ISA_BIT];
  assign csc_irq = st_r.ctrl[CT_CSC_IRQ_LSB +: 4];
  assign fn_irq = st_r.ctrl[CT_FN_IRQ_LSB +: 4];
  assign is_mem = (card_type == CARD_MEM);
  assign is_io = (card_type == CARD_IO);
  assign is_cb = (card_type == CARD_CB);

  // ----------------------------------------------------------------
  // Shared card pins, read by card type
  // ----------------------------------------------------------------
  // One physical pin carries ready or the request; levels, gated by type
  assign io_card_irq_request = card_ready_in & is_io;
  assign cardbus_irq_request = card_ready_in & is_cb;
  // Memory cards never raise a functional request
  assign func_req = io_card_irq_request | cardbus_irq_request;
  // Detect pins are grounded by an inserted card
  assign present = ~card_detect_one_in & ~card_detect_two_in;

  // ----------------------------------------------------------------
  // Legacy flag bank
  // ----------------------------------------------------------------
  // Bit 0 is a battery transition on memory cards, a status assertion on I/O
  assign leg_if.lvl = {power_cycle_done_in, card_ready_in, battery_detect_two_in,
                       battery_detect_one_in};
  assign leg_if.anyedge = {1'b0, 1'b1, 1'b1, is_mem};
  assign leg_if.ena = {~is_cb, is_mem, is_mem, ~is_cb};

  // Clear method chosen by the control bit; a read clears what it returned
  always_comb begin
    leg_if.clr = '0;
    if (wr_done && (paddr_in == OFF_LFLAG) && clr_by_write) begin
      leg_if.clr = pwdata_in[FLAG_W-1:0];
    end else if (rd_done && (paddr_in == OFF_LFLAG) && !clr_by_write) begin
      leg_if.clr = st_r.prdata[FLAG_W-1:0];
    end
  end

  csie_flag_bank #(.W(FLAG_W)) u_leg_bank (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .fi(leg_if)
  );

  // ----------------------------------------------------------------
  // Socket event bank
  // ----------------------------------------------------------------
  // Card detect is watched whatever card is in the socket
  // Raw pin level; gating it by card type would fake an edge on a type change
  assign sock_if.lvl = {power_cycle_done_in, card_detect_two_in, card_detect_one_in,
                        battery_detect_one_in};
  assign sock_if.anyedge = {1'b0, 1'b1, 1'b1, 1'b0};
  assign sock_if.ena = {is_cb, 1'b1, 1'b1, is_cb};

  // Write of 1 clears a socket event
  always_comb begin
    sock_if.clr = '0;
    if (wr_done && (paddr_in == OFF_SEVT)) begin
      sock_if.clr = pwdata_in[FLAG_W-1:0];
    end
  end

  csie_flag_bank #(.W(FLAG_W)) u_sock_bank (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .fi(sock_if)
  );

  // ----------------------------------------------------------------
  // Interrupt sources and routing
  // ----------------------------------------------------------------
  // Status change request while any enabled flag is pending
  assign csc_req = |(leg_if.flag & st_r.lmask) | |(sock_if.flag & st_r.smask);

  // Separate ISA lines for status change and functional requests
  always_comb begin
    isa = '0;
    if (csc_req && csc_isa) begin
      isa[csc_irq] = 1'b1;
    end
    if (func_req && fn_isa) begin
      isa[fn_irq] = 1'b1;
    end
  end

  // Requests not steered to ISA go to this function's PCI line
  assign f0_pci = (csc_req & ~csc_isa) | (func_req & ~fn_isa);
  assign inta = f0_pci | (tie & other_socket_irq_in);
  assign intb = ~tie & other_socket_irq_in;

  // Serial stream carries PCI lines only in the all-serial mode
  assign ser_mode = (mode == MODE_SER_PCI) || (mode == MODE_SER_ALL);
  assign ser_pci = (mode == MODE_SER_ALL);
  assign ser_lines = {ser_pci & intb, ser_pci & inta, isa};

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  // One wait state: pready rises in the second access cycle
  assign acc = psel_in & penable_in;
  assign done = acc & st_r.pready;
  assign wr_done = done & pwrite_in;
  assign rd_done = done & ~pwrite_in;

  // Read data mux; reserved bits read as zero
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (paddr_in)
      OFF_CTRL: begin
        rd_word = {16'h0000, st_r.ctrl};
      end
      OFF_ROUTE: begin
        rd_word = {4'h0, st_r.route};
      end
      OFF_LMASK: begin
        rd_word = {28'h000_0000, st_r.lmask};
      end
      OFF_LFLAG: begin
        rd_word = {28'h000_0000, leg_if.flag};
      end
      OFF_SMASK: begin
        rd_word = {28'h000_0000, st_r.smask};
      end
      OFF_SEVT: begin
        rd_word = {28'h000_0000, sock_if.flag};
      end
      OFF_STAT: begin
        rd_word = {17'h0_0000, multifunction_pins_in, 5'h00, present, csc_req, func_req};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state: bus, registers, serial stream and pins
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    ser_drive = 1'b0;

    // Answer the access; data latched so the read clear sees what was sent
    st_nxt.pready = acc & ~st_r.pready;
    if (acc && !st_r.pready) begin
      st_nxt.pslverr = ~rd_hit;
      st_nxt.prdata = pwrite_in ? 32'h0000_0000 : rd_word;
    end else if (done) begin
      st_nxt.pslverr = 1'b0;
    end

    // Writable registers change at the completing edge only
    if (wr_done && rd_hit) begin
      case (paddr_in)
        OFF_CTRL: begin
          st_nxt.ctrl = pwdata_in[15:0];
        end
        OFF_ROUTE: begin
          st_nxt.route = pwdata_in[27:0];
        end
        OFF_LMASK: begin
          st_nxt.lmask = pwdata_in[3:0];
        end
        OFF_SMASK: begin
          st_nxt.smask = pwdata_in[3:0];
        end
        default: begin
        end
      endcase
    end

    // Serialized stream: start, one slot per line, stop, idle gap
    case (st_r.ser)
      SER_IDLE: begin
        st_nxt.cnt = st_r.cnt + 5'h01;
        if (st_r.cnt == SER_IDLE_CYC - 5'h01) begin
          st_nxt.ser = SER_START;
          st_nxt.cnt = '0;
        end
      end
      SER_START: begin
        ser_drive = 1'b1;
        st_nxt.cnt = st_r.cnt + 5'h01;
        if (st_r.cnt == SER_START_CYC - 5'h01) begin
          st_nxt.ser = SER_SLOT;
          st_nxt.cnt = '0;
          st_nxt.slot = '0;
        end
      end
      SER_SLOT: begin
        // An active line pulls low in the first cycle of its slot
        ser_drive = (st_r.cnt == 5'h00) && ser_lines[st_r.slot];
        st_nxt.cnt = st_r.cnt + 5'h01;
        if (st_r.cnt == SER_SLOT_CYC - 5'h01) begin
          st_nxt.cnt = '0;
          st_nxt.slot = st_r.slot + 5'h01;
          if (st_r.slot == SER_SLOTS - 5'h01) begin
            st_nxt.ser = SER_STOP;
          end
        end
      end
      SER_STOP: begin
        ser_drive = 1'b1;
        st_nxt.cnt = st_r.cnt + 5'h01;
        if (st_r.cnt == SER_STOP_CYC - 5'h01) begin
          st_nxt.ser = SER_IDLE;
          st_nxt.cnt = '0;
        end
      end
      default: begin
        st_nxt.ser = SER_IDLE;
        st_nxt.cnt = '0;
      end
    endcase
    // Stream frozen outside the serial modes so it restarts cleanly
    if (!ser_mode) begin
      st_nxt.ser = SER_IDLE;
      st_nxt.cnt = '0;
      st_nxt.slot = '0;
    end

    // Pins released unless a mode claims them
    st_nxt.mf_out = '0;
    st_nxt.mf_oe = '0;
    // PCI lines are open drain, pulled low while asserted outside the all-serial mode
    if (mode != MODE_SER_ALL) begin
      st_nxt.mf_oe[MF_INTA] = inta;
      st_nxt.mf_oe[MF_INTB] = intb;
    end
    // Parallel ISA levels on the remaining pins, chosen per pin
    if (mode == MODE_ISA_PCI) begin
      for (int k = MF_INTB + 1; k < MF_PINS; k++) begin
        if (st_r.route[k*4 +: 4] != 4'h0) begin
          st_nxt.mf_oe[k] = 1'b1;
          st_nxt.mf_out[k] = isa[st_r.route[k*4 +: 4]];
        end
      end
    end
    // Serial stream owns its pin in the serial modes
    if (ser_mode) begin
      st_nxt.mf_oe[MF_SER] = ser_drive;
      st_nxt.mf_out[MF_SER] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r.pready <= 1'b0;
      st_r.pslverr <= 1'b0;
      st_r.prdata <= 32'h0000_0000;
      st_r.ctrl <= CTRL_RST;
      st_r.route <= ROUTE_RST;
      st_r.lmask <= MASK_RST;
      st_r.smask <= MASK_RST;
      st_r.ser <= SER_IDLE;
      st_r.cnt <= 5'h00;
      st_r.slot <= 5'h00;
      st_r.mf_out <= '0;
      st_r.mf_oe <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign pready_out = st_r.pready;
  assign pslverr_out = st_r.pslverr;
  assign prdata_out = st_r.prdata;
  assign multifunction_pins_out = st_r.mf_out;
  assign multifunction_pins_oe_out = st_r.mf_oe;

endmodule

// ### include/csie_pkg.sv
// Purpose: Shared constants and types of the card socket interrupt events block.
// Assumes: APB register access, one socket, 100 MHz mclk_in.
// Notes: Offsets are byte addresses, one aligned 32-bit word per register.
package csie_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_ROUTE = 12'h004;
  localparam logic [11:0] OFF_LMASK = 12'h008;
  localparam logic [11:0] OFF_LFLAG = 12'h00C;
  localparam logic [11:0] OFF_SMASK = 12'h010;
  localparam logic [11:0] OFF_SEVT = 12'h014;
  localparam logic [11:0] OFF_STAT = 12'h018;

  // ----------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------
  localparam int CT_TYPE_LSB = 0;
  localparam int CT_W1C_BIT = 2;
  localparam int CT_TIE_BIT = 3;
  localparam int CT_MODE_LSB = 4;
  localparam int CT_CSC_ISA_BIT = 6;
  localparam int CT_FN_ISA_BIT = 7;
  localparam int CT_CSC_IRQ_LSB = 8;
  localparam int CT_FN_IRQ_LSB = 12;
  localparam logic [15:0] CTRL_RST = 16'h0030;
  localparam logic [27:0] ROUTE_RST = 28'h000_0000;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [1:0] CARD_MEM = 2'h0;
  localparam logic [1:0] CARD_IO = 2'h1;
  localparam logic [1:0] CARD_CB = 2'h2;
  localparam logic [1:0] MODE_PCI = 2'h0;
  localparam logic [1:0] MODE_ISA_PCI = 2'h1;
  localparam logic [1:0] MODE_SER_PCI = 2'h2;
  localparam logic [1:0] MODE_SER_ALL = 2'h3;

  // ----------------------------------------------------------------
  // Flag layout and pins
  // ----------------------------------------------------------------
  localparam int FLAG_W = 4;
  localparam int LF_BATT1 = 0;
  localparam int LF_BATT2 = 1;
  localparam int LF_READY = 2;
  localparam int LF_PWR = 3;
  localparam int SE_STS = 0;
  localparam int SE_CD1 = 1;
  localparam int SE_CD2 = 2;
  localparam int SE_PWR = 3;
  localparam int MF_PINS = 7;
  localparam int MF_INTA = 0;
  localparam int MF_INTB = 1;
  localparam int MF_SER = 3;

  // ----------------------------------------------------------------
  // Serialized stream timing, in mclk_in cycles
  // ----------------------------------------------------------------
  localparam logic [4:0] SER_START_CYC = 5'h04;
  localparam logic [4:0] SER_SLOT_CYC = 5'h03;
  localparam logic [4:0] SER_SLOTS = 5'h12;
  localparam logic [4:0] SER_STOP_CYC = 5'h02;
  localparam logic [4:0] SER_IDLE_CYC = 5'h08;
  typedef enum logic [1:0] {SER_IDLE, SER_START, SER_SLOT, SER_STOP} csie_ser_state_type;

endpackage

// ### include/csie_flag_if.sv
// Purpose: Carries one bank of event levels, controls, clears and flags.
// Assumes: Driven by the top module, served by csie_flag_bank.
// Notes: W is the number of flags in the bank.
interface csie_flag_if #(parameter int W = 4);
  logic [W-1:0] lvl;
  logic [W-1:0] anyedge;
  logic [W-1:0] ena;
  logic [W-1:0] clr;
  logic [W-1:0] flag;
  modport bank (input lvl, input anyedge, input ena, input clr, output flag);
  modport ctrl (output lvl, output anyedge, output ena, output clr, input flag);
endinterface

// ### src/csie_flag_bank.sv
// Purpose: Edge detection and sticky event flags for one register bank.
// Assumes: Levels are synchronous to mclk_in.
// Notes: Set wins over a clear in the same cycle.
module csie_flag_bank #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Event bank
  csie_flag_if.bank fi
);

  typedef struct packed {
    logic armed;
    logic [W-1:0] prev;
    logic [W-1:0] flag;
  } csie_bank_state_type;

  csie_bank_state_type st_r;
  csie_bank_state_type st_nxt;
  logic [W-1:0] hit;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Armed bit stops the first sampled level from looking like an edge
  always_comb begin
    st_nxt = st_r;
    st_nxt.armed = 1'b1;
    st_nxt.prev = fi.lvl;
    hit = {W{st_r.armed}} & fi.ena &
          ((fi.anyedge & (fi.lvl ^ st_r.prev)) | (~fi.anyedge & fi.lvl & ~st_r.prev));
    st_nxt.flag = (st_r.flag & ~fi.clr) | hit;
  end

  // State register
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fi.flag = st_r.flag;

endmodule

// ### dv/csie_monitor.sv
// Purpose: Port-level checks of the socket interrupt events block.
// Assumes: Single mclk_in domain, reset rst_b_in active low.
// Notes: Sees only csie_top ports; attached by bind below.
module csie_monitor (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [csie_pkg::ADDR_W-1:0] paddr_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [31:0] prdata_out,
  // Multifunction pins
  input wire logic [csie_pkg::MF_PINS-1:0] multifunction_pins_out,
  input wire logic [csie_pkg::MF_PINS-1:0] multifunction_pins_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import csie_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // -----------------------------------------------------------------
  // Register access
  // -----------------------------------------------------------------
  ans_one_wait_a: assert property ($rose(psel_in && penable_in) |=> pready_out)
    else $error("pready late after access");
  ans_one_cycle_a: assert property (pready_out |=> !pready_out)
    else $error("pready held");
  ans_in_access_a: assert property (pready_out |-> psel_in && penable_in)
    else $error("pready outside access");
  err_zero_data_a: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
    else $error("error answer malformed");
  unmapped_err_a: assert property (psel_in && penable_in && !pready_out &&
    paddr_in > OFF_STAT |=> pslverr_out) else $error("unmapped not refused");
  mapped_ok_a: assert property (psel_in && penable_in && !pready_out &&
    paddr_in <= OFF_STAT && paddr_in[1:0] == 2'h0 |=> !pslverr_out) else $error("mapped refused");
  write_no_data_a: assert property (pready_out && pwrite_in |-> prdata_out == 32'h0)
    else $error("write returned data");
  mask_upper_a: assert property (pready_out && !pwrite_in && paddr_in == OFF_LMASK
    |-> prdata_out[31:4] == 28'h0) else $error("mask upper bits set");
  // -----------------------------------------------------------------
  // Interrupt pins
  // -----------------------------------------------------------------
  inta_drain_a: assert property (multifunction_pins_oe_out[MF_INTA]
    |-> !multifunction_pins_out[MF_INTA]) else $error("INTA driven high");
  intb_drain_a: assert property (multifunction_pins_oe_out[MF_INTB]
    |-> !multifunction_pins_out[MF_INTB]) else $error("INTB driven high");
endmodule

bind csie_top csie_monitor mon (.mclk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pready_out, .pslverr_out, .prdata_out, .multifunction_pins_out,
  .multifunction_pins_oe_out);

// ### dv/csie_card_model.sv
// Purpose: Card in the socket, drives the card side pin levels.
// Assumes: Pin order cd1, cd2, batt1, batt2, ready, power done, other.
// Notes: Levels change only at a rising edge, as a synchronised card.
module csie_card_model (
  // Clock
  input wire logic mclk_in,
  // Card pins
  output logic [6:0] card_pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] card_pins_r = 7'h00;
  // Requests stay as levels until the card drops them
  assign card_pins_out = card_pins_r;
  task automatic put(input logic [6:0] v);
    @(posedge mclk_in);
    card_pins_r <= v;
  endtask
endmodule

// ### dv/csie_top_test.sv
// Purpose: Self-checking bench of the socket interrupt events block.
// Assumes: APB master tasks, card model on the socket pins.
// Notes: Pins are pulled up; a pin reads low only while driven low.
module csie_top_test import csie_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in;
  logic rst_b_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd_v;
  logic er_v;
  wire pready;
  wire pslverr;
  wire [31:0] prdata;
  wire [6:0] mf_out;
  wire [6:0] mf_oe;
  wire [6:0] cp;
  wire [6:0] mf_lvl = ~mf_oe | mf_out;
  int err_total = 0;
  int tests_run = 0;
  int n;
  csie_card_model card (.mclk_in(mclk_in), .card_pins_out(cp));
  csie_top uut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
    .card_detect_one_in(cp[0]), .card_detect_two_in(cp[1]),
    .battery_detect_one_in(cp[2]), .battery_detect_two_in(cp[3]),
    .card_ready_in(cp[4]), .power_cycle_done_in(cp[5]), .other_socket_irq_in(cp[6]),
    .multifunction_pins_in(mf_lvl), .multifunction_pins_out(mf_out),
    .multifunction_pins_oe_out(mf_oe));
  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Bounded wait so a dead slave ends as a mismatch, not a hang
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    do begin
      @(posedge mclk_in);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) err_total++;
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd_v, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic pins(input logic [6:0] v);
    card.put(v);
    repeat (3) @(posedge mclk_in);
  endtask
  // One more edge so a register write has reached the pin enables
  task automatic oe_is(input logic [6:0] e);
    @(posedge mclk_in);
    chk({25'h0, mf_oe}, {25'h0, e});
  endtask
  task automatic give_verdict;
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // -----------------------------------------------------------------
  // Clock, watchdog and tests
  // -----------------------------------------------------------------
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // Whole run is well under 2000 cycles
  initial begin
    #100us;
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    rd(OFF_CTRL, 32'h0000_0030);
    rd(OFF_ROUTE, 32'h0);
    rd(OFF_LMASK, 32'h0);
    rd(OFF_SMASK, 32'h0);
    rd(12'h01C, 32'h0);
    chk(32'(er_v), 32'h1);
    // Memory card, parallel PCI only
    wr(OFF_CTRL, 32'h0);
    wr(OFF_LMASK, 32'h0000_000F);
    pins(7'h04);
    oe_is(7'h01);
    rd(OFF_LFLAG, 32'h1);
    rd(OFF_LFLAG, 32'h0);
    oe_is(7'h00);
    pins(7'h08);
    rd(OFF_LFLAG, 32'h3);
    pins(7'h18);
    xfer(1'b0, OFF_STAT, 32'h0);
    chk(32'(rd_v[2:0]), 32'h6);
    rd(OFF_LFLAG, 32'h4);
    pins(7'h38);
    rd(OFF_LFLAG, 32'h8);
    wr(OFF_LMASK, 32'h0);
    pins(7'h1C);
    oe_is(7'h00);
    xfer(1'b0, OFF_LFLAG, 32'h0);
    // Write-one-to-clear legacy flags
    wr(OFF_CTRL, 32'h0000_0004);
    pins(7'h18);
    rd(OFF_LFLAG, 32'h1);
    rd(OFF_LFLAG, 32'h1);
    wr(OFF_LFLAG, 32'h1);
    rd(OFF_LFLAG, 32'h0);
    // I/O card: unmasked request level
    wr(OFF_CTRL, 32'h0000_0001);
    pins(7'h18);
    oe_is(7'h01);
    xfer(1'b0, OFF_STAT, 32'h0);
    chk(32'(rd_v[0]), 32'h1);
    pins(7'h08);
    oe_is(7'h00);
    wr(OFF_LMASK, 32'h1);
    pins(7'h0C);
    rd(OFF_LFLAG, 32'h1);
    // CardBus socket events
    wr(OFF_CTRL, 32'h0000_0002);
    wr(OFF_SMASK, 32'h0000_000F);
    pins(7'h0F);
    rd(OFF_SEVT, 32'h6);
    rd(OFF_SEVT, 32'h6);
    oe_is(7'h01);
    wr(OFF_SEVT, 32'h6);
    rd(OFF_SEVT, 32'h0);
    pins(7'h0B);
    pins(7'h2F);
    rd(OFF_SEVT, 32'h9);
    rd(OFF_LFLAG, 32'h0);
    wr(OFF_SEVT, 32'h9);
    pins(7'h3F);
    oe_is(7'h01);
    pins(7'h4F);
    oe_is(7'h02);
    wr(OFF_CTRL, 32'h0000_000A);
    oe_is(7'h01);
    wr(OFF_CTRL, 32'h0000_0002);
    pins(7'h0F);
    oe_is(7'h00);
    // Parallel ISA IRQ on pin 2 beside PCI
    wr(OFF_ROUTE, 32'h0000_0500);
    wr(OFF_CTRL, 32'h0000_0552);
    oe_is(7'h04);
    pins(7'h0D);
    chk(32'(mf_out[2]), 32'h1);
    oe_is(7'h04);
    wr(OFF_SEVT, 32'h0000_000F);
    // Functional request steered to ISA line 5 on pin 2, INTA quiet
    wr(OFF_CTRL, 32'h0000_5092);
    pins(7'h1D);
    oe_is(7'h04);
    chk(32'(mf_out[2]), 32'h1);
    // Serial ISA with parallel PCI: request back on INTA
    wr(OFF_CTRL, 32'h0000_0022);
    @(posedge mclk_in);
    chk(32'(mf_oe[0]), 32'h1);
    // Serialized stream low pulses on pin 3
    wr(OFF_CTRL, 32'h0000_0032);
    n = 0;
    while (!(mf_oe[3] === 1'b1 && mf_out[3] === 1'b0) && n < 200) begin
      @(posedge mclk_in);
      n++;
    end
    chk(32'(n < 200), 32'h1);
    give_verdict();
  end
endmodule
